//--- ecl_defines.vh
`ifndef ECL_DEFINES_VH
`define ECL_DEFINES_VH

// Configuration word indices in the serial memory
`define ECL_W_MAC0 3'h0
`define ECL_W_MAC1 3'h1
`define ECL_W_MAC2 3'h2
`define ECL_W_CTL 3'h3
`define ECL_W_VID 3'h4
`define ECL_W_PID 3'h5
`define ECL_W_PIN 3'h6
`define ECL_W_WAKE 3'h7
`define ECL_W_LAST 3'h7

// Accept code and low bit of each accept field in the control word
`define ECL_ACC_CODE 2'h1
`define ECL_ACC_ID 4'h0
`define ECL_ACC_PIN 4'h2
`define ECL_ACC_WK 4'h6
`define ECL_ACC_LED 4'ha
`define ECL_ACC_PHY 4'hc
`define ECL_ACC_REUSE 4'he

// Pin control word fields
`define ECL_PIN_CS 0
`define ECL_PIN_RD 1
`define ECL_PIN_WR 2
`define ECL_PIN_INTLOW 3
`define ECL_PIN_INTOD 4

// Wake-up word fields
`define ECL_WK_LOW 0
`define ECL_WK_PULSE 1
`define ECL_WK_MAGIC 2
`define ECL_WK_LINK 3
`define ECL_WK_LEDM 7
`define ECL_WK_PHY 8
`define ECL_WK_L2_HI 13
`define ECL_WK_L2_LO 12
`define ECL_WK_XOVER 14
`define ECL_WK_L1 15

// Built-in defaults
`define ECL_DEF_CS_LOW 1'b1
`define ECL_DEF_RD_LOW 1'b1
`define ECL_DEF_WR_LOW 1'b1
`define ECL_DEF_INT_LOW 1'b0
`define ECL_DEF_INT_OD 1'b0
`define ECL_DEF_WK_LOW 1'b0
`define ECL_DEF_WK_PULSE 1'b0
`define ECL_DEF_MAGIC 1'b0
`define ECL_DEF_LINK 1'b0
`define ECL_DEF_LEDM 1'b0
`define ECL_DEF_PHY 1'b0
`define ECL_DEF_L2 2'h0
`define ECL_DEF_XOVER 1'b1
`define ECL_DEF_L1 1'b0

// Second indicator reuse codes
`define ECL_L2_STALL 2'h1
`define ECL_L2_WAKE 2'h2

`endif

//--- ecl_out_pins.v
`timescale 1ns/1ps
`include "ecl_defines.vh"

module ecl_out_pins (
    input wire clk,
    input wire rstn,
    input wire ce,
    input wire int_evt,
    input wire int_low,
    input wire int_od,
    input wire wake_evt,
    input wire wake_low,
    input wire wake_pulse,
    output reg int_o,
    output reg int_oe,
    output reg wake_o,
    output wire wake_lvl
);
    // Previous wake request, for the pulse edge
    reg wake_prev_q;
    // Asserted wake meaning, before polarity
    reg wake_act;

    assign wake_lvl = wake_act;

    // Level mode follows the request; pulse mode gives one cycle
    always @*
    begin
        if (wake_pulse)
            wake_act = wake_evt & ~wake_prev_q;
        else
            wake_act = wake_evt;
    end

    // Registered pin drive, defaults are push-pull active high
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            int_o <= 1'b0;
            int_oe <= 1'b1;
            wake_o <= 1'b0;
            wake_prev_q <= 1'b0;
        end
        else if (ce)
        begin
            wake_prev_q <= wake_evt;
            // [RL11] interrupt polarity select
            int_o <= int_evt ^ int_low;
            // [RL12] open collector drives active only
            int_oe <= int_od ? int_evt : 1'b1;
            // [RL13] wake polarity select
            wake_o <= wake_act ^ wake_low;
        end
    end
endmodule // ecl_out_pins

//--- ecl_led_mux.v
`timescale 1ns/1ps
`include "ecl_defines.vh"

module ecl_led_mux (
    input wire clk,
    input wire rstn,
    input wire ce,
    input wire mode_8bit,
    input wire [1:0] l2_sel,
    input wire l1_wide,
    input wire act1,
    input wire act2,
    input wire stall,
    input wire wake_lvl,
    output reg pin1,
    output reg pin2
);
    // Pin reuse only exists in 16-bit host mode
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pin1 <= 1'b0;
            pin2 <= 1'b0;
        end
        else if (ce)
        begin
            // [RL21] first indicator shows width
            if (!mode_8bit && l1_wide)
                pin1 <= 1'b1;
            else
                pin1 <= act1;
            // [RL19] second indicator reuse
            if (!mode_8bit && l2_sel == `ECL_L2_STALL)
                pin2 <= stall;
            else if (!mode_8bit && l2_sel == `ECL_L2_WAKE)
                pin2 <= wake_lvl;
            else
                pin2 <= act2;
        end
    end
endmodule // ecl_led_mux

//--- ecl_loader.v
// Functional notes
// [RL1] Words 0-2 give station address
// [RL2] Code 01 in 1:0 loads IDs
// [RL3] Code 01 in 3:2 applies word6
// [RL4] Code 01 in 7:6, 8-bit applies word7[3:0]
// [RL5] Code 01 in 11:10 applies LED mode
// [RL6] Code 01 in 13:12 applies PHY enable
// [RL7] Code 01 in 15:14 applies word7[15:12]
// [RL8] Vendor ID from word 4, else default
// [RL9] Product ID from word 5, else default
// [RL10] Word6 bits 0-2 host strobe polarity
// [RL11] Word6 bit3 interrupt active low
// [RL12] Word6 bit4 interrupt open collector
// [RL13] Word7 bit0 wake active low
// [RL14] Word7 bit1 wake pulse mode
// [RL15] Word7 bit2 magic packet wake
// [RL16] Word7 bit3 link change wake
// [RL17] Word7 bit7 LED mode 1
// [RL18] Word7 bit8 PHY on after power-on
// [RL19] Word7 13:12 second indicator reuse
// [RL20] Word7 bit14 automatic crossover enable
// [RL21] Word7 bit15 first indicator shows width
// [RL22] Other accept codes keep defaults
// [RL23] Settings apply after all words read
`timescale 1ns/1ps
`include "ecl_defines.vh"

module ecl_loader #(
    // Arbitrary identity values, not tied to any maker
    parameter [15:0] DEF_VENDOR_ID = 16'h1234,
    parameter [15:0] DEF_PRODUCT_ID = 16'h5678,
    // Station address used until a load completes
    parameter [47:0] DEF_STATION = 48'h0,
    // Number of configuration words fetched
    parameter integer WORDS = 8
) (
    CLK_SYS,
    RSTN,
    CE,
    MODE_8BIT,
    RD_REQ,
    RD_ADDR,
    RD_ACK,
    RD_DATA,
    LOAD_DONE,
    STATION_ADDR,
    VENDOR_ID,
    PRODUCT_ID,
    CHIP_SEL_IN,
    READ_STROBE_IN,
    WRITE_STROBE_IN,
    CHIP_SEL_ACT,
    READ_ACT,
    WRITE_ACT,
    INT_EVENT,
    INT_O,
    INT_OE,
    WAKE_EVENT,
    WAKE_O,
    MAGIC_WAKE_EN,
    LINK_WAKE_EN,
    LED_MODE1,
    PHY_PWR_EN,
    AUTO_XOVER_EN,
    FIRST_IND_ACT,
    SECOND_IND_ACT,
    BUS_STALL_IN,
    FIRST_INDICATOR_PIN,
    SECOND_INDICATOR_PIN
);
    input wire CLK_SYS;
    input wire RSTN;
    input wire CE;
    input wire MODE_8BIT;
    output wire RD_REQ;
    output wire [2:0] RD_ADDR;
    input wire RD_ACK;
    input wire [15:0] RD_DATA;
    output wire LOAD_DONE;
    output wire [47:0] STATION_ADDR;
    output wire [15:0] VENDOR_ID;
    output wire [15:0] PRODUCT_ID;
    input wire CHIP_SEL_IN;
    input wire READ_STROBE_IN;
    input wire WRITE_STROBE_IN;
    output reg CHIP_SEL_ACT;
    output reg READ_ACT;
    output reg WRITE_ACT;
    input wire INT_EVENT;
    output wire INT_O;
    output wire INT_OE;
    input wire WAKE_EVENT;
    output wire WAKE_O;
    output wire MAGIC_WAKE_EN;
    output wire LINK_WAKE_EN;
    output wire LED_MODE1;
    output wire PHY_PWR_EN;
    output wire AUTO_XOVER_EN;
    input wire FIRST_IND_ACT;
    input wire SECOND_IND_ACT;
    input wire BUS_STALL_IN;
    output wire FIRST_INDICATOR_PIN;
    output wire SECOND_INDICATOR_PIN;

    // One-hot loader states
    localparam [3:0] ST_RESET = 4'h1;
    localparam [3:0] ST_FETCH = 4'h2;
    localparam [3:0] ST_APPLY = 4'h4;
    localparam [3:0] ST_DONE = 4'h8;

    // True when a two-bit accept field holds the accept code
    function accept;
        input [15:0] ctl;
        input [3:0] lsb;
        reg [15:0] sh;
        begin
            sh = ctl >> lsb;
            accept = (sh[1:0] == `ECL_ACC_CODE);
        end
    endfunction

    // Loader state and word index
    reg [3:0] state_q;
    reg [3:0] state_d;
    reg [2:0] idx_q;
    reg [2:0] idx_d;
    // Raw configuration words, flip-flop storage by index
    reg [15:0] word_q [0:WORDS-1];

    // Applied settings, defaults until the load completes
    reg [47:0] station_q;
    reg [15:0] vendor_q;
    reg [15:0] product_q;
    reg cs_low_q;
    reg rd_low_q;
    reg wr_low_q;
    reg int_low_q;
    reg int_od_q;
    reg wk_low_q;
    reg wk_pulse_q;
    reg magic_q;
    reg link_q;
    reg ledm_q;
    reg phy_q;
    reg [1:0] l2_q;
    reg xover_q;
    reg l1_q;
    reg done_q;
    // Wake level before polarity, shared with the indicator mux
    wire wake_lvl;
    // Word just captured from the memory
    wire take;
    // Control word once fetched
    wire [15:0] ctl;
    integer i;

    assign take = state_q[1] & RD_ACK;
    assign ctl = word_q[`ECL_W_CTL];

    // Request stays up while fetching; the memory side acks
    assign RD_REQ = state_q[1];
    assign RD_ADDR = idx_q;

    assign LOAD_DONE = done_q;
    assign STATION_ADDR = station_q;
    assign VENDOR_ID = vendor_q;
    assign PRODUCT_ID = product_q;
    assign MAGIC_WAKE_EN = magic_q;
    assign LINK_WAKE_EN = link_q;
    assign LED_MODE1 = ledm_q;
    assign PHY_PWR_EN = phy_q;
    assign AUTO_XOVER_EN = xover_q;

    // Next state: fetch every word, then apply once
    always @*
    begin
        state_d = state_q;
        idx_d = idx_q;
        case (state_q)
            ST_RESET:
            begin
                state_d = ST_FETCH;
                idx_d = `ECL_W_MAC0;
            end
            ST_FETCH:
            begin
                // [RL23] all words before any apply
                if (RD_ACK)
                begin
                    if (idx_q == `ECL_W_LAST)
                        state_d = ST_APPLY;
                    else
                        idx_d = idx_q + 3'h1;
                end
            end
            ST_APPLY:
                state_d = ST_DONE;
            ST_DONE:
                state_d = ST_DONE;
            default:
                state_d = ST_RESET;
        endcase
    end

    // State register and word capture
    always @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            state_q <= ST_RESET;
            idx_q <= 3'h0;
            for (i = 0; i < WORDS; i = i + 1)
                word_q[i] <= 16'h0;
        end
        else if (CE)
        begin
            state_q <= state_d;
            idx_q <= idx_d;
            if (take)
                word_q[idx_q] <= RD_DATA;
        end
    end

    // Identity and address; copied once in the apply state
    always @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            station_q <= DEF_STATION;
            vendor_q <= DEF_VENDOR_ID;
            product_q <= DEF_PRODUCT_ID;
            done_q <= 1'b0;
        end
        else if (CE && state_q[2])
        begin
            done_q <= 1'b1;
            // [RL1] low byte of word 0 is offset 0
            station_q <= {word_q[`ECL_W_MAC2],
                          word_q[`ECL_W_MAC1],
                          word_q[`ECL_W_MAC0]};
            // [RL2] identifiers replaced on accept
            if (accept(ctl, `ECL_ACC_ID))
            begin
                // [RL8] vendor identifier from word 4
                vendor_q <= word_q[`ECL_W_VID];
                // [RL9] product identifier from word 5
                product_q <= word_q[`ECL_W_PID];
            end
        end
    end

    // Host pin control settings from word 6
    always @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            cs_low_q <= `ECL_DEF_CS_LOW;
            rd_low_q <= `ECL_DEF_RD_LOW;
            wr_low_q <= `ECL_DEF_WR_LOW;
            int_low_q <= `ECL_DEF_INT_LOW;
            int_od_q <= `ECL_DEF_INT_OD;
        end
        // [RL3] word 6 pin settings on accept
        else if (CE && state_q[2] && accept(ctl, `ECL_ACC_PIN))
        begin
            // [RL10] strobe polarities loaded
            cs_low_q <= word_q[`ECL_W_PIN][`ECL_PIN_CS];
            rd_low_q <= word_q[`ECL_W_PIN][`ECL_PIN_RD];
            wr_low_q <= word_q[`ECL_W_PIN][`ECL_PIN_WR];
            int_low_q <= word_q[`ECL_W_PIN][`ECL_PIN_INTLOW];
            int_od_q <= word_q[`ECL_W_PIN][`ECL_PIN_INTOD];
        end
    end

    // Wake-up, indicator and PHY settings from word 7
    always @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            wk_low_q <= `ECL_DEF_WK_LOW;
            wk_pulse_q <= `ECL_DEF_WK_PULSE;
            magic_q <= `ECL_DEF_MAGIC;
            link_q <= `ECL_DEF_LINK;
            ledm_q <= `ECL_DEF_LEDM;
            phy_q <= `ECL_DEF_PHY;
            l2_q <= `ECL_DEF_L2;
            xover_q <= `ECL_DEF_XOVER;
            l1_q <= `ECL_DEF_L1;
        end
        else if (CE && state_q[2])
        begin
            // [RL4] wake group only in 8-bit mode
            if (accept(ctl, `ECL_ACC_WK) && MODE_8BIT)
            begin
                // [RL13] wake polarity bit
                wk_low_q <= word_q[`ECL_W_WAKE][`ECL_WK_LOW];
                // [RL14] wake pulse or level
                wk_pulse_q <= word_q[`ECL_W_WAKE][`ECL_WK_PULSE];
                // [RL15] magic packet wake enable
                magic_q <= word_q[`ECL_W_WAKE][`ECL_WK_MAGIC];
                // [RL16] link change wake enable
                link_q <= word_q[`ECL_W_WAKE][`ECL_WK_LINK];
            end
            // [RL5] LED mode on accept
            if (accept(ctl, `ECL_ACC_LED))
                // [RL17] select indicator mode 1
                ledm_q <= word_q[`ECL_W_WAKE][`ECL_WK_LEDM];
            // [RL6] PHY enable on accept
            if (accept(ctl, `ECL_ACC_PHY))
                // [RL18] PHY stays powered
                phy_q <= word_q[`ECL_W_WAKE][`ECL_WK_PHY];
            // [RL7] upper nibble on accept
            if (accept(ctl, `ECL_ACC_REUSE))
            begin
                l2_q <= word_q[`ECL_W_WAKE]
                    [`ECL_WK_L2_HI:`ECL_WK_L2_LO];
                // [RL20] crossover detection switch
                xover_q <= word_q[`ECL_W_WAKE][`ECL_WK_XOVER];
                l1_q <= word_q[`ECL_W_WAKE][`ECL_WK_L1];
            end
            // [RL22] any other code keeps defaults
        end
    end

    // Host strobes turned into asserted meaning; registered so the
    // polarity swap at load time never glitches the host logic
    always @(posedge CLK_SYS or negedge RSTN)
    begin
        if (!RSTN)
        begin
            CHIP_SEL_ACT <= 1'b0;
            READ_ACT <= 1'b0;
            WRITE_ACT <= 1'b0;
        end
        else if (CE)
        begin
            // [RL10] polarity applied to strobes
            CHIP_SEL_ACT <= CHIP_SEL_IN ^ cs_low_q;
            READ_ACT <= READ_STROBE_IN ^ rd_low_q;
            WRITE_ACT <= WRITE_STROBE_IN ^ wr_low_q;
        end
    end

    // Interrupt and wake pin drivers
    ecl_out_pins u_pins (
        .clk(CLK_SYS),
        .rstn(RSTN),
        .ce(CE),
        .int_evt(INT_EVENT),
        .int_low(int_low_q),
        .int_od(int_od_q),
        .wake_evt(WAKE_EVENT),
        .wake_low(wk_low_q),
        .wake_pulse(wk_pulse_q),
        .int_o(INT_O),
        .int_oe(INT_OE),
        .wake_o(WAKE_O),
        .wake_lvl(wake_lvl)
    );

    // Indicator pin reuse
    ecl_led_mux u_led (
        .clk(CLK_SYS),
        .rstn(RSTN),
        .ce(CE),
        .mode_8bit(MODE_8BIT),
        .l2_sel(l2_q),
        .l1_wide(l1_q),
        .act1(FIRST_IND_ACT),
        .act2(SECOND_IND_ACT),
        .stall(BUS_STALL_IN),
        .wake_lvl(wake_lvl),
        .pin1(FIRST_INDICATOR_PIN),
        .pin2(SECOND_INDICATOR_PIN)
    );
endmodule // ecl_loader

//--- ecl_mem_model.sv
`timescale 1ns/1ps

// Word store standing in for the serial memory behind the loader
module ecl_mem_model (
    input wire clk,
    input wire req,
    input wire [2:0] addr,
    input wire [3:0] lat,
    output reg ack = 1'b0,
    output reg [15:0] data = 16'h0
);
    reg [15:0] mem [0:7]; // Start-up words, filled by the bench
    reg [3:0] cnt = 4'h0; // Wait cycles before answering

    // Answer after lat idle cycles; lat 0 acks every cycle
    always @(posedge clk)
    begin
        #1;
        if (!req)
        begin
            ack = 1'b0;
            cnt = 4'h0;
        end
        else if (ack)
        begin
            // Word was taken at this edge
            ack = (lat == 4'h0);
            cnt = 4'h0;
        end
        else if (cnt >= lat)
            ack = 1'b1;
        else
            cnt = cnt + 4'h1;
        // Released data flips so a stale word never looks valid
        data = ack ? mem[addr] : ~data;
    end
endmodule // ecl_mem_model

//--- ecl_loader_chk.sv
`timescale 1ns/1ps

// Port-level checks of the start-up loader
module ecl_loader_chk (
    input logic CLK_SYS,
    input logic RSTN,
    input logic CE,
    input logic RD_REQ,
    input logic [2:0] RD_ADDR,
    input logic RD_ACK,
    input logic LOAD_DONE,
    input logic [47:0] STATION_ADDR,
    input logic [15:0] VENDOR_ID,
    input logic CHIP_SEL_IN,
    input logic READ_STROBE_IN,
    input logic WRITE_STROBE_IN,
    input logic CHIP_SEL_ACT,
    input logic READ_ACT,
    input logic WRITE_ACT,
    input logic INT_EVENT,
    input logic INT_O,
    input logic INT_OE,
    input logic WAKE_EVENT,
    input logic WAKE_O,
    input logic MAGIC_WAKE_EN,
    input logic LINK_WAKE_EN,
    input logic LED_MODE1,
    input logic PHY_PWR_EN,
    input logic AUTO_XOVER_EN
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);

    property p_addr_step;
        RD_REQ && RD_ACK && CE && RD_ADDR != 3'h7
            |=> RD_ADDR == $past(RD_ADDR) + 3'h1;
    endproperty
    a_addr_step: assert property (p_addr_step)
        else $error("bad step");
    property p_addr_hold;
        RD_REQ && !RD_ACK |=> $stable(RD_ADDR);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("addr moved");
    property p_done_after;
        $rose(LOAD_DONE) |-> !$past(RD_REQ) && $past(RD_ACK, 2)
            && $past(RD_ADDR, 2) == 3'h7;
    endproperty
    a_done_after: assert property (p_done_after)
        else $error("early");
    property p_done_hold;
        LOAD_DONE |=> LOAD_DONE && !RD_REQ;
    endproperty
    a_done_hold: assert property (p_done_hold)
        else $error("done lost");
    property p_keep;
        LOAD_DONE |=> $stable(VENDOR_ID) && $stable(STATION_ADDR);
    endproperty
    a_keep: assert property (p_keep)
        else $error("setting moved");
    // Before the load ends only the built-in polarities may act
    property p_strobe_def;
        !LOAD_DONE && $past(RSTN) |-> {CHIP_SEL_ACT, READ_ACT, WRITE_ACT}
            == ~$past({CHIP_SEL_IN, READ_STROBE_IN, WRITE_STROBE_IN});
    endproperty
    a_strobe_def: assert property (p_strobe_def)
        else $error("strobe");
    property p_int_def;
        !LOAD_DONE && $past(RSTN) |-> INT_OE && INT_O == $past(INT_EVENT);
    endproperty
    a_int_def: assert property (p_int_def)
        else $error("int default");
    property p_od;
        !INT_OE |-> !$past(INT_EVENT);
    endproperty
    a_od: assert property (p_od)
        else $error("released when active");
    property p_wake_def;
        !LOAD_DONE && $past(RSTN) |-> WAKE_O == $past(WAKE_EVENT);
    endproperty
    a_wake_def: assert property (p_wake_def)
        else $error("wake default");
    property p_set_def;
        !LOAD_DONE |-> AUTO_XOVER_EN && !PHY_PWR_EN && !MAGIC_WAKE_EN
            && !LINK_WAKE_EN && !LED_MODE1;
    endproperty
    a_set_def: assert property (p_set_def)
        else $error("early apply");

    c_done: cover property ($rose(LOAD_DONE));
    c_stall: cover property (RD_REQ && !RD_ACK);
    c_od: cover property (!INT_OE);
endmodule // ecl_loader_chk

//--- tb_ecl_loader.sv
`timescale 1ns/1ps

module tb_ecl_loader;
    reg clk_sys = 1'b0;
    reg rstn = 1'b0;
    reg ce = 1'b1; // Clock enable, dropped once to prove the freeze
    reg mode_8bit = 1'b1;
    reg cs_in = 1'b1, rd_in = 1'b1, wr_in = 1'b1;
    reg int_ev = 1'b0, wk_ev = 1'b0, l1 = 1'b0, l2 = 1'b0, stall = 1'b0;
    reg [3:0] lat = 4'h0; // Memory answer delay
    wire rd_req, rd_ack, load_done, cs_act, rd_act, wr_act, int_o, int_oe;
    wire wk_o, magic, link, ledm, phy, xover, pin1, pin2;
    wire [2:0] rd_addr;
    wire [15:0] rd_data, vid, pid;
    wire [47:0] station;
    integer n_errors = 0;
    integer num_checks = 0;

    always #12.5 clk_sys = ~clk_sys;

    ecl_loader dut_u (.CLK_SYS(clk_sys), .RSTN(rstn), .CE(ce),
        .MODE_8BIT(mode_8bit), .RD_REQ(rd_req), .RD_ADDR(rd_addr),
        .RD_ACK(rd_ack), .RD_DATA(rd_data), .LOAD_DONE(load_done),
        .STATION_ADDR(station), .VENDOR_ID(vid), .PRODUCT_ID(pid),
        .CHIP_SEL_IN(cs_in), .READ_STROBE_IN(rd_in),
        .WRITE_STROBE_IN(wr_in), .CHIP_SEL_ACT(cs_act), .READ_ACT(rd_act),
        .WRITE_ACT(wr_act), .INT_EVENT(int_ev), .INT_O(int_o),
        .INT_OE(int_oe), .WAKE_EVENT(wk_ev), .WAKE_O(wk_o),
        .MAGIC_WAKE_EN(magic), .LINK_WAKE_EN(link), .LED_MODE1(ledm),
        .PHY_PWR_EN(phy), .AUTO_XOVER_EN(xover), .FIRST_IND_ACT(l1),
        .SECOND_IND_ACT(l2), .BUS_STALL_IN(stall),
        .FIRST_INDICATOR_PIN(pin1),
        .SECOND_INDICATOR_PIN(pin2));

    ecl_mem_model mem_u (.clk(clk_sys), .req(rd_req), .addr(rd_addr),
        .lat(lat), .ack(rd_ack), .data(rd_data));

    task check(input [47:0] seen, input [47:0] exp);
    begin
        num_checks = num_checks + 1;
        if (seen !== exp)
        begin
            n_errors = n_errors + 1;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask

    task tick;
    begin
        @(posedge clk_sys);
        #1;
    end
    endtask

    // Reset, fill the store, wait for the load under a bound
    task load(input [15:0] ctl, w6, w7, input m, input [3:0] l);
        integer i;
    begin
        mem_u.mem[0] = 16'h2211;
        mem_u.mem[1] = 16'h4433;
        mem_u.mem[2] = 16'h6655;
        mem_u.mem[3] = ctl;
        mem_u.mem[4] = 16'hbeef;
        mem_u.mem[5] = 16'hcafe;
        mem_u.mem[6] = w6;
        mem_u.mem[7] = w7;
        mode_8bit = m;
        lat = l;
        rstn = 1'b0;
        repeat (16) tick;
        rstn = 1'b1;
        i = 0;
        while (load_done !== 1'b1 && i < 200)
        begin
            tick;
            i = i + 1;
        end
        check(load_done, 1'b1);
        check(station, 48'h665544332211);
    end
    endtask

    // Codes 10 and 11 everywhere: nothing may leave its default
    task t_defaults;
    begin
        load(16'hfffe, 16'hffff, 16'hffff, 1'b1, 4'h0);
        check({vid, pid}, 32'h12345678);
        check({xover, phy, magic, link, ledm}, 5'h10);
        cs_in = 1'b0;
        wr_in = 1'b0;
        int_ev = 1'b1;
        tick;
        check({cs_act, rd_act, wr_act}, 3'b101);
        check({int_o, int_oe}, 2'b11);
        int_ev = 1'b0;
        wk_ev = 1'b1;
        tick;
        check({int_o, int_oe}, 2'b01);
        tick;
        check(wk_o, 1'b1);
        wk_ev = 1'b0;
        // Clock enable low: a fresh request must not reach the pin
        ce = 1'b0;
        int_ev = 1'b1;
        tick;
        check({int_o, int_oe}, 2'b01);
        ce = 1'b1;
        int_ev = 1'b0;
        $display("defaults test done");
    end
    endtask

    // Every field accepted, slow memory, 8-bit host
    task t_all;
        integer k, lows;
    begin
        load(16'h5445, 16'h0018, 16'h918f, 1'b1, 4'h3);
        check({vid, pid}, 32'hbeefcafe);
        check({magic, link}, 2'b11);
        check(ledm, 1'b1);
        check(phy, 1'b1);
        check(xover, 1'b0);
        cs_in = 1'b1;
        rd_in = 1'b0;
        wr_in = 1'b1;
        int_ev = 1'b1;
        l1 = 1'b0;
        l2 = 1'b1;
        stall = 1'b0;
        tick;
        tick;
        check({cs_act, rd_act, wr_act}, 3'b101);
        check({int_o, int_oe}, 2'b01);
        check({pin1, pin2}, 2'b01);
        // The pulse shows right after the first edge that sees the request
        int_ev = 1'b0;
        wk_ev = 1'b1;
        lows = 0;
        for (k = 0; k < 6; k = k + 1)
        begin
            tick;
            if (k == 0)
                check(int_oe, 1'b0);
            if (wk_o === 1'b0)
                lows = lows + 1;
        end
        check(lows, 1);
        check(wk_o, 1'b1);
        wk_ev = 1'b0;
        $display("accept test done");
    end
    endtask

    // 16-bit host: pin reuse acts, wake group must not
    task t_reuse;
    begin
        load(16'h4042, 16'h0000, 16'h900f, 1'b0, 4'h1);
        check(magic, 1'b0);
        check(vid, 16'h1234);
        check(xover, 1'b0);
        l1 = 1'b0;
        l2 = 1'b0;
        stall = 1'b1;
        tick;
        tick;
        check({pin1, pin2}, 2'b11);
        stall = 1'b0;
        tick;
        tick;
        check(pin2, 1'b0);
        load(16'h4000, 16'h0000, 16'h2000, 1'b0, 4'h0);
        wk_ev = 1'b1;
        repeat (3) tick;
        check({pin1, pin2}, 2'b01);
        wk_ev = 1'b0;
        $display("reuse test done");
    end
    endtask

    task finish_test;
    begin
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask

    initial
    begin
        #1;
        t_defaults;
        t_all;
        t_reuse;
        finish_test;
    end

    // Whole run needs under 400 cycles
    initial
    begin
        #100000;
        n_errors = n_errors + 1;
        finish_test;
    end
endmodule // tb_ecl_loader

bind ecl_loader ecl_loader_chk chk_u (.CLK_SYS, .RSTN, .CE, .RD_REQ,
    .RD_ADDR, .RD_ACK, .LOAD_DONE, .STATION_ADDR, .VENDOR_ID, .CHIP_SEL_IN,
    .READ_STROBE_IN, .WRITE_STROBE_IN, .CHIP_SEL_ACT, .READ_ACT, .WRITE_ACT,
    .INT_EVENT, .INT_O, .INT_OE, .WAKE_EVENT, .WAKE_O, .MAGIC_WAKE_EN,
    .LINK_WAKE_EN, .LED_MODE1, .PHY_PWR_EN, .AUTO_XOVER_EN);
